/* hdl/tmr16_pkg.sv */
// Constants and carrier types of the 16-bit timer with capture and two compares.
// Assumes a classic Wishbone slave with 32-bit data, 8-bit registers in bits 7:0.
package tmr16_pkg;
	localparam logic [7:0] ADR_CTRL_A = 8'h00;
	localparam logic [7:0] ADR_CTRL_B = 8'h04;
	localparam logic [7:0] ADR_FORCE = 8'h08;
	localparam logic [7:0] ADR_CNT_L = 8'h0C;
	localparam logic [7:0] ADR_CNT_H = 8'h10;
	localparam logic [7:0] ADR_OCRA_L = 8'h14;
	localparam logic [7:0] ADR_OCRA_H = 8'h18;
	localparam logic [7:0] ADR_OCRB_L = 8'h1C;
	localparam logic [7:0] ADR_OCRB_H = 8'h20;
	localparam logic [7:0] ADR_ICR_L = 8'h24;
	localparam logic [7:0] ADR_ICR_H = 8'h28;
	localparam logic [7:0] ADR_IEN = 8'h2C;
	localparam logic [7:0] ADR_FLAGS = 8'h30;
	localparam int FORCE_A_BIT = 7;
	localparam int FORCE_B_BIT = 6;
	localparam int F_CAP = 5;
	localparam int F_CMPB = 2;
	localparam int F_CMPA = 1;
	localparam int F_OVF = 0;
	localparam logic [7:0] IRQ_MASK = 8'h27;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam int PS_W = 10;
	localparam int PS_B8 = 3;
	localparam int PS_B64 = 6;
	localparam int PS_B256 = 8;
	localparam int PS_B1024 = 10;
	localparam int FILT_LEN = 4;
	// Clock select codes
	typedef enum logic [2:0] {
		CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
	} tmr16_cs_t;
	// Control register A: compare output modes and low mode bits
	typedef struct packed {
		logic [1:0] com_a;
		logic [1:0] com_b;
		logic [1:0] rsvd;
		logic [1:0] wgm_lo;
	} tmr16_ctrl_a_t;
	// Control register B: capture and clock control
	typedef struct packed {
		logic filt_en;
		logic edge_rise;
		logic rsvd;
		logic [1:0] wgm_hi;
		tmr16_cs_t cs;
	} tmr16_ctrl_b_t;
endpackage : tmr16_pkg

/* hdl/tmr16_timer.sv */
// 16-bit timer/counter: registers, prescaler, counter, compares, capture.
// Assumes pins arrive asynchronously; vector acknowledges come from the core clock.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
module tmr16_timer (
	input wire logic clk_i, // 125 MHz I/O clock
	input wire logic nrst_i, // Synchronous reset, low active
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte selects
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic capture_input_pin_i, // Capture pin
	input wire logic external_clock_pin_i, // External count pin
	input wire logic acomp_i, // Comparator output
	input wire logic acomp_sel_i, // Capture from comparator
	input wire logic glob_ie_i, // Global interrupt enable
	input wire logic [7:0] irq_ack_i, // Vector executed, flag layout
	output logic [7:0] irq_req_o, // Requests, flag layout
	output logic wave_out_a_o, // Waveform A
	output logic wave_out_b_o // Waveform B
);
	tmr16_pkg::tmr16_ctrl_a_t ctrl_a_reg;
	tmr16_pkg::tmr16_ctrl_b_t ctrl_b_reg;
	logic [15:0] cnt_reg, ocra_reg, ocrb_reg, icr_reg;
	logic [7:0] temp_reg, ien_reg, flag_reg, flag_set, flag_clr, rd_next;
	logic [tmr16_pkg::PS_W-1:0] ps_reg;
	logic ext_s1, ext_s2, ext_s3, cap_s1, cap_s2;
	logic [tmr16_pkg::FILT_LEN-1:0] smp_reg;
	logic filt_reg, prev_reg, block_reg, up_reg, wa_reg, wb_reg;
	logic acc, wr, rd, cnt_wr, tick, src, cap_lvl, cap_ev;
	logic [3:0] wgm;
	logic [15:0] top;
	logic pwm, fast, dual, icr_top, at_top, m_a, m_b, f_a, f_b, ovf_ev;

	// Mode decode helpers
	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] oa,
		input logic [15:0] ic);
		case (m)
			4'h1, 4'h5: top_of = 16'h00FF;
			4'h2, 4'h6: top_of = 16'h01FF;
			4'h3, 4'h7: top_of = 16'h03FF;
			4'h4, 4'h9, 4'hB, 4'hF: top_of = oa;
			4'h8, 4'hA, 4'hC, 4'hE: top_of = ic;
			default: top_of = tmr16_pkg::CNT_MAX;
		endcase
	endfunction : top_of

	function automatic logic ps_hit(input logic [tmr16_pkg::PS_W-1:0] p, input int b);
		logic [tmr16_pkg::PS_W-1:0] msk;
		msk = tmr16_pkg::PS_W'((1 << b) - 1);
		ps_hit = (p & msk) == msk;
	endfunction : ps_hit

	// Next waveform level from compare, force and top events
	function automatic logic wave_nx(input logic [1:0] com, input logic cur, input logic m,
		input logic f, input logic t, input logic up, input logic fs, input logic du,
		input logic tgl);
		wave_nx = cur;
		if (!fs && !du) begin
			if (m || f) begin
				case (com)
					2'b01: wave_nx = ~cur;
					2'b10: wave_nx = 1'b0;
					2'b11: wave_nx = 1'b1;
					default: wave_nx = cur;
				endcase
			end
		end else if (com[1]) begin
			if (m) begin
				wave_nx = (fs || up) ? com[0] : ~com[0];
			end else if (fs && t) begin
				wave_nx = ~com[0];
			end
		end else if (com[0] && tgl && m) begin
			wave_nx = ~cur;
		end
	endfunction : wave_nx

	// Mode classification
	assign wgm = {ctrl_b_reg.wgm_hi, ctrl_a_reg.wgm_lo};
	assign top = top_of(wgm, ocra_reg, icr_reg);
	assign fast = (wgm inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});
	assign dual = (wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
	assign pwm = fast || dual;
	assign icr_top = (wgm inside {4'h8, 4'hA, 4'hC, 4'hE});
	assign at_top = (cnt_reg == top);

	// Bus decode
	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = acc && wb_we_i && wb_sel_i[0];
	assign rd = acc && !wb_we_i;
	assign cnt_wr = wr && (wb_adr_i == tmr16_pkg::ADR_CNT_L);
	assign f_a = wr && (wb_adr_i == tmr16_pkg::ADR_FORCE) && !pwm &&
		wb_dat_i[tmr16_pkg::FORCE_A_BIT];
	assign f_b = wr && (wb_adr_i == tmr16_pkg::ADR_FORCE) && !pwm &&
		wb_dat_i[tmr16_pkg::FORCE_B_BIT];

	// Pin synchronisers
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			{ext_s1, ext_s2, ext_s3, cap_s1, cap_s2} <= 5'h00;
		end else begin
			ext_s1 <= external_clock_pin_i;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			cap_s1 <= capture_input_pin_i;
			cap_s2 <= cap_s1;
		end
	end

	// Free-running prescaler
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ps_reg <= '0;
		end else begin
			ps_reg <= ps_reg + 1'b1;
		end
	end

	// Timer clock enable; pin is sensed whatever its direction
	always_comb begin
		case (ctrl_b_reg.cs)
			tmr16_pkg::CS_DIV1: tick = 1'b1;
			tmr16_pkg::CS_DIV8: tick = ps_hit(ps_reg, tmr16_pkg::PS_B8);
			tmr16_pkg::CS_DIV64: tick = ps_hit(ps_reg, tmr16_pkg::PS_B64);
			tmr16_pkg::CS_DIV256: tick = ps_hit(ps_reg, tmr16_pkg::PS_B256);
			tmr16_pkg::CS_DIV1024: tick = ps_hit(ps_reg, tmr16_pkg::PS_B1024);
			tmr16_pkg::CS_EXT_FALL: tick = !ext_s2 && ext_s3;
			tmr16_pkg::CS_EXT_RISE: tick = ext_s2 && !ext_s3;
			default: tick = 1'b0;
		endcase
	end

	// Capture source, filter and edge detect
	assign src = acomp_sel_i ? acomp_i : cap_s2;
	assign cap_lvl = ctrl_b_reg.filt_en ? filt_reg : src;
	assign cap_ev = !icr_top &&
		(ctrl_b_reg.edge_rise ? (cap_lvl && !prev_reg) : (!cap_lvl && prev_reg));
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			smp_reg <= '0;
			filt_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			smp_reg <= {smp_reg[tmr16_pkg::FILT_LEN-2:0], src};
			if (&smp_reg) begin
				filt_reg <= 1'b1;
			end else if (~|smp_reg) begin
				filt_reg <= 1'b0;
			end
			prev_reg <= cap_lvl;
		end
	end

	// Compare matches, blocked on the tick after a counter write
	assign m_a = tick && !block_reg && (cnt_reg == ocra_reg);
	assign m_b = tick && !block_reg && (cnt_reg == ocrb_reg);
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			block_reg <= 1'b0;
		end else if (cnt_wr) begin
			block_reg <= 1'b1;
		end else if (tick) begin
			block_reg <= 1'b0;
		end
	end

	// Counter; bus write has priority over counting
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cnt_reg <= 16'h0000;
			up_reg <= 1'b1;
		end else if (cnt_wr) begin
			cnt_reg <= {temp_reg, wb_dat_i[7:0]};
		end else if (tick) begin
			if (!dual) begin
				cnt_reg <= at_top ? 16'h0000 : cnt_reg + 16'h0001;
			end else if (up_reg && cnt_reg >= top) begin
				up_reg <= 1'b0;
				cnt_reg <= cnt_reg - 16'h0001;
			end else if (!up_reg && cnt_reg == 16'h0000) begin
				up_reg <= 1'b1;
				cnt_reg <= 16'h0001;
			end else begin
				cnt_reg <= up_reg ? cnt_reg + 16'h0001 : cnt_reg - 16'h0001;
			end
		end
	end

	// Waveform outputs; force gives the non-PWM action only
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wa_reg <= 1'b0;
			wb_reg <= 1'b0;
		end else begin
			wa_reg <= wave_nx(ctrl_a_reg.com_a, wa_reg, m_a, f_a, tick && at_top, up_reg,
				fast, dual, wgm inside {4'h9, 4'hB, 4'hF});
			wb_reg <= wave_nx(ctrl_a_reg.com_b, wb_reg, m_b, f_b, tick && at_top, up_reg,
				fast, dual, 1'b0);
		end
	end
	assign wave_out_a_o = wa_reg;
	assign wave_out_b_o = wb_reg;

	// Flag events; force strobes never reach these
	always_comb begin
		if (fast) begin
			ovf_ev = tick && at_top;
		end else if (dual) begin
			ovf_ev = tick && !up_reg && cnt_reg == 16'h0000;
		end else begin
			ovf_ev = tick && cnt_reg == tmr16_pkg::CNT_MAX;
		end
		flag_set = 8'h00;
		flag_set[tmr16_pkg::F_CAP] = cap_ev || (icr_top && tick && at_top);
		flag_set[tmr16_pkg::F_CMPB] = m_b;
		flag_set[tmr16_pkg::F_CMPA] = m_a;
		flag_set[tmr16_pkg::F_OVF] = ovf_ev;
		flag_clr = irq_ack_i;
		if (wr && wb_adr_i == tmr16_pkg::ADR_FLAGS) begin
			flag_clr = flag_clr | wb_dat_i[7:0];
		end
	end

	// Flags and gated requests; set wins over clear
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			flag_reg <= tmr16_pkg::REG_RESET;
			irq_req_o <= 8'h00;
		end else begin
			flag_reg <= (flag_set | (flag_reg & ~flag_clr)) & tmr16_pkg::IRQ_MASK;
			irq_req_o <= flag_reg & ien_reg & {8{glob_ie_i}};
		end
	end

	// Capture register: hardware load or bus write
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			icr_reg <= 16'h0000;
		end else if (cap_ev) begin
			icr_reg <= cnt_reg;
		end else if (wr && wb_adr_i == tmr16_pkg::ADR_ICR_L) begin
			icr_reg <= {temp_reg, wb_dat_i[7:0]};
		end
	end

	// Shared high-byte temp: filled by high writes and by counter and capture low reads
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			temp_reg <= 8'h00;
		end else if (wr && wb_adr_i inside {tmr16_pkg::ADR_CNT_H, tmr16_pkg::ADR_OCRA_H,
			tmr16_pkg::ADR_OCRB_H, tmr16_pkg::ADR_ICR_H}) begin
			temp_reg <= wb_dat_i[7:0];
		end else if (rd && wb_adr_i == tmr16_pkg::ADR_CNT_L) begin
			temp_reg <= cnt_reg[15:8];
		end else if (rd && wb_adr_i == tmr16_pkg::ADR_ICR_L) begin
			temp_reg <= icr_reg[15:8];
		end
	end

	// Plain control and compare registers
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ctrl_a_reg <= tmr16_pkg::REG_RESET;
			ctrl_b_reg <= tmr16_pkg::REG_RESET;
			ien_reg <= tmr16_pkg::REG_RESET;
			ocra_reg <= 16'h0000;
			ocrb_reg <= 16'h0000;
		end else if (wr) begin
			case (wb_adr_i)
				tmr16_pkg::ADR_CTRL_A: ctrl_a_reg <= wb_dat_i[7:0];
				tmr16_pkg::ADR_CTRL_B: ctrl_b_reg <= wb_dat_i[7:0] & 8'hDF;
				tmr16_pkg::ADR_IEN: ien_reg <= wb_dat_i[7:0] & tmr16_pkg::IRQ_MASK;
				tmr16_pkg::ADR_OCRA_L: ocra_reg <= {temp_reg, wb_dat_i[7:0]};
				tmr16_pkg::ADR_OCRB_L: ocrb_reg <= {temp_reg, wb_dat_i[7:0]};
				default: ;
			endcase
		end
	end

	// Read mux; force register and unmapped read zero
	always_comb begin
		case (wb_adr_i)
			tmr16_pkg::ADR_CTRL_A: rd_next = ctrl_a_reg;
			tmr16_pkg::ADR_CTRL_B: rd_next = ctrl_b_reg;
			tmr16_pkg::ADR_CNT_L: rd_next = cnt_reg[7:0];
			tmr16_pkg::ADR_CNT_H: rd_next = temp_reg;
			tmr16_pkg::ADR_OCRA_L: rd_next = ocra_reg[7:0];
			tmr16_pkg::ADR_OCRA_H: rd_next = ocra_reg[15:8];
			tmr16_pkg::ADR_OCRB_L: rd_next = ocrb_reg[7:0];
			tmr16_pkg::ADR_OCRB_H: rd_next = ocrb_reg[15:8];
			tmr16_pkg::ADR_ICR_L: rd_next = icr_reg[7:0];
			tmr16_pkg::ADR_ICR_H: rd_next = temp_reg;
			tmr16_pkg::ADR_IEN: rd_next = ien_reg;
			tmr16_pkg::ADR_FLAGS: rd_next = flag_reg;
			default: rd_next = 8'h00;
		endcase
	end

	// Bus answer, one cycle after the request
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= rd ? {24'h00_0000, rd_next} : 32'h0000_0000;
		end
	end

	a_force_rd_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rd && wb_adr_i == tmr16_pkg::ADR_FORCE |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
		else $error("force register read nonzero");
	a_rsvd_bit_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wr && wb_adr_i == tmr16_pkg::ADR_CTRL_B |=> !ctrl_b_reg.rsvd && wb_ack_o)
		else $error("reserved control bit stored");
	a_capture_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
		cap_ev |=> icr_reg == $past(cnt_reg) && flag_reg[tmr16_pkg::F_CAP])
		else $error("capture did not load counter");
	a_capture_off_top: assert property (@(posedge clk_i) disable iff (!nrst_i)
		icr_top |-> !cap_ev)
		else $error("capture while capture register is top");
	a_cmpa_flag_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(flag_reg[tmr16_pkg::F_CMPA]) |-> $past(tick && cnt_reg == ocra_reg && !block_reg))
		else $error("compare flag without a match");
	a_cnt_wr_block: assert property (@(posedge clk_i) disable iff (!nrst_i)
		cnt_wr ##1 tick |-> !m_a && !m_b)
		else $error("match after counter write");
	a_stop_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
		ctrl_b_reg.cs == tmr16_pkg::CS_STOP && !cnt_wr |=> $stable(cnt_reg))
		else $error("stopped counter moved");
	a_set_beats_clr: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(flag_set & flag_clr & tmr16_pkg::IRQ_MASK) != 8'h00
		|=> (flag_reg & $past(flag_set & flag_clr)) == ($past(flag_set & flag_clr) & tmr16_pkg::IRQ_MASK))
		else $error("flag event lost to clear");
	a_irq_gating: assert property (@(posedge clk_i) disable iff (!nrst_i)
		irq_req_o[tmr16_pkg::F_OVF] |-> $past(flag_reg[tmr16_pkg::F_OVF]
		&& ien_reg[tmr16_pkg::F_OVF] && glob_ie_i))
		else $error("request not gated");
	a_ovf_normal: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wgm == 4'h0 && tick && !cnt_wr && cnt_reg == tmr16_pkg::CNT_MAX
		|=> flag_reg[tmr16_pkg::F_OVF] && cnt_reg == 16'h0000)
		else $error("overflow not flagged");
endmodule : tmr16_timer

/* bench/tb.sv */
// Testbench of the 16-bit timer: register access, compares, force, capture, clock select.
// Assumes a one-cycle Wishbone answer and pins synchronised inside the timer.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic cap_pin = 1'b0;
	logic ext_pin = 1'b0;
	logic glob_ie = 1'b0;
	logic [7:0] ack_v = 8'h00;
	logic [31:0] rdat;
	logic ack;
	logic [7:0] irq;
	logic wa;
	logic wb;
	logic w;
	int fails = 0;
	int tests_run = 0;

	// Free-running 125 MHz clock
	always #4 clk_i = ~clk_i;

	tmr16_timer dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .capture_input_pin_i(cap_pin), .external_clock_pin_i(ext_pin),
		.acomp_i(1'b0), .acomp_sel_i(1'b0), .glob_ie_i(glob_ie), .irq_ack_i(ack_v),
		.irq_req_o(irq), .wave_out_a_o(wa), .wave_out_b_o(wb));

	// Prints the counts and the verdict, then ends the run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One classic cycle, held until ack is sampled high
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= wr;
		adr <= a;
		wdat <= {24'h00_0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat[7:0];
		cyc <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) begin
			fails++;
			give_verdict();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(nm, {8'h00, q}, {8'h00, e});
	endtask : rdc

	// High byte first, low byte commits
	task automatic wr16(input logic [7:0] ah, input logic [7:0] al, input logic [15:0] v);
		wr(ah, v[15:8]);
		wr(al, v[7:0]);
	endtask : wr16

	// Low byte first; counter and capture low reads latch the high byte
	task automatic rd16c(input string nm, input logic [7:0] al, input logic [7:0] ah,
			input logic [15:0] e);
		logic [7:0] lo;
		logic [7:0] hi;
		bus(1'b0, al, 8'h00, lo);
		bus(1'b0, ah, 8'h00, hi);
		chk(nm, {hi, lo}, e);
	endtask : rd16c

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	// Reset values, masks, write-only and unmapped places, 16-bit round trip
	task automatic t_regs();
		rdc("ctrl_b rst", tmr16_pkg::ADR_CTRL_B, 8'h00);
		rdc("ien rst", tmr16_pkg::ADR_IEN, 8'h00);
		wr(tmr16_pkg::ADR_CTRL_B, 8'hFF);
		rdc("ctrl_b rsvd", tmr16_pkg::ADR_CTRL_B, 8'hDF);
		wr(tmr16_pkg::ADR_CTRL_B, 8'h00);
		wr(tmr16_pkg::ADR_IEN, 8'hFF);
		rdc("ien mask", tmr16_pkg::ADR_IEN, 8'h27);
		wr(tmr16_pkg::ADR_FORCE, 8'hC0);
		rdc("force rd", tmr16_pkg::ADR_FORCE, 8'h00);
		rdc("unmapped", 8'hFC, 8'h00);
		wr16(tmr16_pkg::ADR_OCRA_H, tmr16_pkg::ADR_OCRA_L, 16'hA55A);
		wr16(tmr16_pkg::ADR_OCRB_H, tmr16_pkg::ADR_OCRB_L, 16'h5AA5);
		rd16c("ocra", tmr16_pkg::ADR_OCRA_L, tmr16_pkg::ADR_OCRA_H, 16'hA55A);
		rd16c("ocrb", tmr16_pkg::ADR_OCRB_L, tmr16_pkg::ADR_OCRB_H, 16'h5AA5);
		wr(tmr16_pkg::ADR_IEN, 8'h00);
	endtask : t_regs

	// Compare matches, request gating, acknowledge and write-one clearing
	task automatic t_cmp();
		wr16(tmr16_pkg::ADR_CNT_H, tmr16_pkg::ADR_CNT_L, 16'h0010);
		wr16(tmr16_pkg::ADR_OCRA_H, tmr16_pkg::ADR_OCRA_L, 16'h0014);
		wr16(tmr16_pkg::ADR_OCRB_H, tmr16_pkg::ADR_OCRB_L, 16'h0018);
		wr(tmr16_pkg::ADR_IEN, 8'h06);
		glob_ie <= 1'b1;
		wr(tmr16_pkg::ADR_CTRL_B, 8'h01);
		tick(30);
		wr(tmr16_pkg::ADR_CTRL_B, 8'h00);
		rdc("cmp flags", tmr16_pkg::ADR_FLAGS, 8'h06);
		chk("irq on", {8'h00, irq}, 16'h0006);
		glob_ie <= 1'b0;
		tick(3);
		chk("irq global off", {8'h00, irq}, 16'h0000);
		glob_ie <= 1'b1;
		ack_v <= 8'h02;
		tick(1);
		ack_v <= 8'h00;
		tick(2);
		rdc("vector clear", tmr16_pkg::ADR_FLAGS, 8'h04);
		wr(tmr16_pkg::ADR_FLAGS, 8'h04);
		rdc("w1c clear", tmr16_pkg::ADR_FLAGS, 8'h00);
		tick(2);
		chk("irq idle", {8'h00, irq}, 16'h0000);
		wr(tmr16_pkg::ADR_IEN, 8'h00);
	endtask : t_cmp

	// Force toggles in normal mode without a flag, does nothing in PWM
	task automatic t_force();
		logic w2;
		wr(tmr16_pkg::ADR_CTRL_A, 8'h50);
		tick(2);
		w = wa;
		w2 = wb;
		wr(tmr16_pkg::ADR_FORCE, 8'hC0);
		tick(3);
		chk("force toggle a", {15'h0000, wa}, {15'h0000, ~w});
		chk("force toggle b", {15'h0000, wb}, {15'h0000, ~w2});
		rdc("force no flag", tmr16_pkg::ADR_FLAGS, 8'h00);
		wr(tmr16_pkg::ADR_CTRL_A, 8'h51);
		tick(2);
		w = wa;
		w2 = wb;
		wr(tmr16_pkg::ADR_FORCE, 8'hC0);
		tick(3);
		chk("force pwm a", {15'h0000, wa}, {15'h0000, w});
		chk("force pwm b", {15'h0000, wb}, {15'h0000, w2});
		wr(tmr16_pkg::ADR_FORCE, 8'h00);
		wr(tmr16_pkg::ADR_CTRL_A, 8'h00);
	endtask : t_force

	// Capture edges, filter, and capture shut off while it serves as top
	task automatic t_cap();
		wr16(tmr16_pkg::ADR_CNT_H, tmr16_pkg::ADR_CNT_L, 16'h1234);
		wr(tmr16_pkg::ADR_CTRL_B, 8'h40);
		cap_pin <= 1'b1;
		tick(10);
		rdc("cap rise", tmr16_pkg::ADR_FLAGS, 8'h20);
		rd16c("icr", tmr16_pkg::ADR_ICR_L, tmr16_pkg::ADR_ICR_H, 16'h1234);
		wr(tmr16_pkg::ADR_FLAGS, 8'h20);
		cap_pin <= 1'b0;
		tick(10);
		rdc("cap fall ign", tmr16_pkg::ADR_FLAGS, 8'h00);
		wr(tmr16_pkg::ADR_CTRL_B, 8'hC0);
		cap_pin <= 1'b1;
		tick(2);
		cap_pin <= 1'b0;
		tick(12);
		rdc("filt glitch", tmr16_pkg::ADR_FLAGS, 8'h00);
		cap_pin <= 1'b1;
		tick(12);
		rdc("filt pass", tmr16_pkg::ADR_FLAGS, 8'h20);
		wr(tmr16_pkg::ADR_FLAGS, 8'h20);
		wr(tmr16_pkg::ADR_CTRL_B, 8'h00);
		cap_pin <= 1'b0;
		tick(10);
		rdc("cap fall", tmr16_pkg::ADR_FLAGS, 8'h20);
		wr(tmr16_pkg::ADR_FLAGS, 8'h20);
		wr(tmr16_pkg::ADR_CTRL_B, 8'h58);
		cap_pin <= 1'b1;
		tick(10);
		rdc("cap top off", tmr16_pkg::ADR_FLAGS, 8'h00);
		wr(tmr16_pkg::ADR_CTRL_B, 8'h00);
	endtask : t_cap

	// External pin counting on both edge choices
	task automatic t_ext();
		wr16(tmr16_pkg::ADR_CNT_H, tmr16_pkg::ADR_CNT_L, 16'h0000);
		wr(tmr16_pkg::ADR_CTRL_B, 8'h07);
		repeat (3) begin
			ext_pin <= 1'b1;
			tick(5);
			ext_pin <= 1'b0;
			tick(5);
		end
		tick(6);
		wr(tmr16_pkg::ADR_CTRL_B, 8'h06);
		repeat (2) begin
			ext_pin <= 1'b1;
			tick(5);
			ext_pin <= 1'b0;
			tick(5);
		end
		tick(6);
		wr(tmr16_pkg::ADR_CTRL_B, 8'h00);
		rd16c("ext count", tmr16_pkg::ADR_CNT_L, tmr16_pkg::ADR_CNT_H, 16'h0005);
	endtask : t_ext

	// Overflow in normal mode sets its flag and a gated request
	task automatic t_ovf();
		wr(tmr16_pkg::ADR_IEN, 8'h01);
		wr16(tmr16_pkg::ADR_CNT_H, tmr16_pkg::ADR_CNT_L, 16'hFFF8);
		wr(tmr16_pkg::ADR_CTRL_B, 8'h01);
		tick(10);
		wr(tmr16_pkg::ADR_CTRL_B, 8'h00);
		rdc("ovf flag", tmr16_pkg::ADR_FLAGS, 8'h01);
		chk("irq ovf", {8'h00, irq}, 16'h0001);
		wr(tmr16_pkg::ADR_FLAGS, 8'h01);
		wr(tmr16_pkg::ADR_IEN, 8'h00);
	endtask : t_ovf

	// Main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_regs();
		t_cmp();
		t_force();
		t_cap();
		t_ext();
		t_ovf();
		give_verdict();
	end
endmodule : tb
